// ### core/ppp_pkg.sv
// Package for the parallel programming port: command codes, pin groups,
// page geometry and timing counts.
// Assumes a 100 MHz ref_clk and one synchronous active-high reset.
package ppp_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    // Strobe pulses shorter than this are the programmer's fault
    localparam int STROBE_MIN_NS = 250;
    localparam int STROBE_MIN_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Entry pins must be still this long after high voltage
    localparam int ENTRY_STILL_NS = 100;
    localparam int ENTRY_STILL_CYC = (ENTRY_STILL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Strobe toggles needed while reset is low
    localparam logic [3:0] ENTRY_TOGGLES = 4'h6;

    // ----------------------------------------
    // Action select codes
    // ----------------------------------------
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;
    localparam logic [1:0] ACT_IDLE = 2'h3;

    // ----------------------------------------
    // Command bytes
    // ----------------------------------------
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
    localparam logic [7:0] CMD_RD_SIG = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EEPROM = 8'h03;

    // ----------------------------------------
    // Memory geometry
    // ----------------------------------------
    localparam int WORD_BITS = 5;          // Words in a page, as a bit count
    localparam int PAGE_WORDS = 1 << WORD_BITS;
    localparam int ADDR_BITS = 16;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [15:0] ERASED_WORD = 16'hffff;

    // Pins sampled from the programmer
    typedef struct packed {
        logic strobe_clock_pin;
        logic action_sel_zero;
        logic action_sel_one_byte_sel_two;
        logic page_latch_byte_sel_one;
        logic write_n;
        logic output_enable_n;
        logic high_voltage;
    } ppp_pins_t;

    // Requests handed to the storage back end
    typedef struct packed {
        logic flash_page_write;
        logic eeprom_page_write;
        logic erase_flash;
        logic erase_eeprom;
        logic clear_locks;
        logic fuse_write;
        logic lock_write;
        logic [1:0] byte_sel;
        logic [ADDR_BITS-1:0] addr;
        logic [7:0] data;
    } ppp_nvm_req_t;

endpackage

// ### core/ppp_sync.sv
// Two-flop synchroniser for a bundle of programmer pins.
// Assumes inputs are asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module ppp_sync (
    input wire logic ref_clk,
    input wire logic reset,
    input wire ppp_pkg::ppp_pins_t pins_in,
    output ppp_pkg::ppp_pins_t pins_out
);
    import ppp_pkg::*;

    // First stage, read only by the second
    ppp_pins_t stage_one;

    // ----------------------------------------
    // Two flip-flop chain
    // ----------------------------------------
    // Idle values: write and enable strobes high, everything else low
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stage_one <= '{write_n: 1'b1, output_enable_n: 1'b1, default: 1'b0};
            pins_out <= '{write_n: 1'b1, output_enable_n: 1'b1, default: 1'b0};
        end else begin
            stage_one <= pins_in;
            pins_out <= stage_one;
        end
    end
endmodule
`default_nettype wire

// ### core/ppp_port.sv
// Device side of the parallel programming port: entry, command, address and
// data latching, page buffer, and execution of write and read commands.
// Assumes the storage back end acts on nvm_req pulses and reports done.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Strobe rise loads address, data or command
// - Byte select one picks low/high byte
// - Write/enable strobes execute latest command
// - Decode write-type command bytes
// - Decode read-type command bytes
// - Ready/busy low during programming operations
// - Drive data bus only while enable low
// - Entry pins still 100 ns after voltage
// - Command and address retained across operations
// - Address high byte stays latched
// - Erase clears flash, eeprom, locks; fuses kept
// - Keep-eeprom fuse preserves eeprom on erase
// - Erase starts on write strobe, busy
// - Flash data words latched into page buffer
// - Flash write programs page, busy until done
// - Zero command ends page programming
// - Low bits pick word, high bits page
module ppp_port (
    input wire logic ref_clk,
    input wire logic reset,
    input wire ppp_pkg::ppp_pins_t pins,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic ready_busy_flag,
    output logic prog_mode,
    input wire logic keep_eeprom_fuse,
    output ppp_pkg::ppp_nvm_req_t nvm_req,
    input wire logic nvm_done,
    input wire logic [7:0] nvm_rd_data
);
    import ppp_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    typedef enum logic [1:0] {PPP_OFF, PPP_ARM, PPP_SETTLE, PPP_ON} ppp_entry_t;
    typedef enum logic [1:0] {PPP_IDLE, PPP_ERASE_MEM, PPP_ERASE_LOCK, PPP_WAIT} ppp_op_t;

    ppp_pins_t sp;                    // Synchronised pins
    ppp_pins_t prev;                  // Previous sample for edge detection
    ppp_entry_t entry;                // Entry sequence state
    ppp_op_t op;                      // Operation state
    logic [3:0] toggles;              // Strobe rises counted with reset low
    logic [7:0] settle;               // Stillness counter after high voltage
    logic [7:0] command;              // Latched command byte
    logic [7:0] addr_lo;              // Address low byte
    logic [7:0] addr_hi;              // Address high byte
    logic [7:0] data_lo;              // Data low byte
    logic [7:0] data_meta; // Data bus pins, first flop
    logic [7:0] data_sync; // Data bus pins, second flop
    logic [15:0] page_buf [PAGE_WORDS]; // Flash page buffer
    logic [7:0] ee_buf [PAGE_WORDS];    // EEPROM page buffer
    logic strobe_rise;
    logic write_fall;
    logic [3:0] entry_pins;
    logic [3:0] prev_entry_pins;
    logic [1:0] action;

    // Write-type command check, used by decode and execution
    function automatic logic is_write_cmd(input logic [7:0] c);
        return c == CMD_CHIP_ERASE || c == CMD_WR_FUSE || c == CMD_WR_LOCK
            || c == CMD_WR_FLASH || c == CMD_WR_EEPROM;
    endfunction

    // Word index within a page
    function automatic logic [WORD_BITS-1:0] word_in_page(input logic [7:0] lo);
        return lo[WORD_BITS-1:0];
    endfunction

    ppp_sync u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pins_in(pins),
        .pins_out(sp)
    );

    assign strobe_rise = sp.strobe_clock_pin && !prev.strobe_clock_pin;
    assign write_fall = !sp.write_n && prev.write_n;
    assign action = {sp.action_sel_one_byte_sel_two, sp.action_sel_zero};
    assign entry_pins = {sp.page_latch_byte_sel_one, sp.action_sel_one_byte_sel_two,
                         sp.action_sel_zero, sp.write_n};
    assign prev_entry_pins = {prev.page_latch_byte_sel_one, prev.action_sel_one_byte_sel_two,
                              prev.action_sel_zero, prev.write_n};

    // Edge history
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prev <= '{write_n: 1'b1, output_enable_n: 1'b1, default: 1'b0};
        end else begin
            prev <= sp;
        end
    end

    // Data bus crosses in beside the pins, so strobe and byte stay aligned
    always_ff @(posedge ref_clk) begin
        data_meta <= data_in;
        data_sync <= data_meta;
    end

    // ----------------------------------------
    // Programming mode entry
    // ----------------------------------------
    // Programmer supplies the toggles and entry code
    // check entry stillness
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            entry <= PPP_OFF;
            toggles <= 4'h0;
            settle <= 8'h00;
        end else begin
            unique case (entry)
                PPP_OFF: begin
                    // Count rises only while high voltage absent
                    if (sp.high_voltage) begin
                        toggles <= 4'h0;
                    end else if (strobe_rise && toggles != ENTRY_TOGGLES) begin
                        toggles <= toggles + 4'h1;
                    end
                    if (toggles == ENTRY_TOGGLES && !sp.high_voltage) begin
                        entry <= PPP_ARM;
                    end
                end
                PPP_ARM: begin
                    // Wait for high voltage with entry pins at zero
                    if (sp.high_voltage) begin
                        settle <= 8'h00;
                        entry <= (entry_pins == 4'h0) ? PPP_SETTLE : PPP_OFF;
                    end
                end
                PPP_SETTLE: begin
                    // Any entry pin change or loss of high voltage during the window aborts entry
                    if (!sp.high_voltage || entry_pins != prev_entry_pins) begin
                        entry <= PPP_OFF;
                        toggles <= 4'h0;
                    end else if (settle == 8'(ENTRY_STILL_CYC - 1)) begin
                        entry <= PPP_ON;
                    end else begin
                        settle <= settle + 8'h01;
                    end
                end
                PPP_ON: begin
                    // Dropping the high voltage leaves programming mode
                    if (!sp.high_voltage) begin
                        entry <= PPP_OFF;
                        toggles <= 4'h0;
                    end
                end
            endcase
        end
    end

    assign prog_mode = (entry == PPP_ON);

    // ----------------------------------------
    // Byte loading on strobe rise
    // ----------------------------------------
    // load by action code; idle code ignored; values retained
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            command <= CMD_NOP;
            addr_lo <= 8'h00;
            addr_hi <= 8'h00;
            data_lo <= 8'h00;
        end else if (prog_mode && strobe_rise && op == PPP_IDLE) begin
            unique case (action)
                ACT_ADDR: begin
                    // byte select picks address byte; high byte kept
                    if (sp.page_latch_byte_sel_one) begin
                        addr_hi <= data_sync;
                    end else begin
                        addr_lo <= data_sync;
                    end
                end
                ACT_DATA: begin
                    if (!sp.page_latch_byte_sel_one) begin
                        data_lo <= data_sync;
                    end
                end
                ACT_CMD: command <= data_sync;
                ACT_IDLE: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Page buffers
    // ----------------------------------------
    // high byte completes word into page buffer
    // low address bits pick the word
    always_ff @(posedge ref_clk) begin
        if (prog_mode && strobe_rise && op == PPP_IDLE && action == ACT_DATA) begin
            if (command == CMD_WR_FLASH && sp.page_latch_byte_sel_one) begin
                page_buf[word_in_page(addr_lo)] <= {data_sync, data_lo};
            end else if (command == CMD_WR_EEPROM && !sp.page_latch_byte_sel_one) begin
                ee_buf[word_in_page(addr_lo)] <= data_sync;
            end
        end
    end

    // ----------------------------------------
    // Operation execution
    // ----------------------------------------
    // write strobe runs latched command; decode
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            op <= PPP_IDLE;
            nvm_req <= '0;
        end else begin
            // Requests are single-cycle pulses
            nvm_req.flash_page_write <= 1'b0;
            nvm_req.eeprom_page_write <= 1'b0;
            nvm_req.erase_flash <= 1'b0;
            nvm_req.erase_eeprom <= 1'b0;
            nvm_req.clear_locks <= 1'b0;
            nvm_req.fuse_write <= 1'b0;
            nvm_req.lock_write <= 1'b0;
            unique case (op)
                PPP_IDLE: begin
                    if (prog_mode && write_fall && is_write_cmd(command)) begin
                        nvm_req.byte_sel <= action;
                        nvm_req.addr <= {addr_hi, addr_lo};
                        nvm_req.data <= data_lo;
                        op <= PPP_WAIT;
                        unique case (command)
                            // memories first; keep eeprom if fused
                            CMD_CHIP_ERASE: begin
                                nvm_req.erase_flash <= 1'b1;
                                nvm_req.erase_eeprom <= !keep_eeprom_fuse;
                                op <= PPP_ERASE_MEM;
                            end
                            CMD_WR_FLASH: nvm_req.flash_page_write <= 1'b1;
                            CMD_WR_EEPROM: nvm_req.eeprom_page_write <= 1'b1;
                            CMD_WR_FUSE: nvm_req.fuse_write <= 1'b1;
                            default: nvm_req.lock_write <= 1'b1;
                        endcase
                    end
                end
                PPP_ERASE_MEM: begin
                    // locks cleared only after memory erased
                    if (nvm_done) begin
                        nvm_req.clear_locks <= 1'b1;
                        op <= PPP_ERASE_LOCK;
                    end
                end
                PPP_ERASE_LOCK: begin
                    if (nvm_done) begin
                        op <= PPP_IDLE;
                    end
                end
                PPP_WAIT: begin
                    if (nvm_done) begin
                        op <= PPP_IDLE;
                    end
                end
            endcase
        end
    end

    assign ready_busy_flag = (op == PPP_IDLE);

    // ----------------------------------------
    // Read path and data bus drive
    // ----------------------------------------
    // read decode; drive only with enable low
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end else begin
            data_oe <= prog_mode && !sp.output_enable_n;
            unique case (command)
                CMD_RD_FLASH, CMD_RD_EEPROM, CMD_RD_SIG, CMD_RD_FUSE: data_out <= nvm_rd_data;
                default: data_out <= ERASED_BYTE;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    busy_on_write_a: assert property (@(posedge ref_clk) disable iff (reset)
        (prog_mode && op == PPP_IDLE && write_fall && is_write_cmd(command))
        |=> !ready_busy_flag) else $error("busy not raised on write");
    idle_no_load_a: assert property (@(posedge ref_clk) disable iff (reset)
        (strobe_rise && action == ACT_IDLE) |=> $stable(command) && $stable(addr_lo)
        && $stable(addr_hi) && $stable(data_lo)) else $error("idle code changed state");
    cmd_load_a: assert property (@(posedge ref_clk) disable iff (reset)
        (prog_mode && op == PPP_IDLE && strobe_rise && action == ACT_CMD)
        |=> command == $past(data_sync)) else $error("command not loaded");
    addr_hi_a: assert property (@(posedge ref_clk) disable iff (reset)
        (prog_mode && op == PPP_IDLE && strobe_rise && action == ACT_ADDR
        && sp.page_latch_byte_sel_one) |=> addr_hi == $past(data_sync) && $stable(addr_lo))
        else $error("address high byte load wrong");
    bus_drive_a: assert property (@(posedge ref_clk) disable iff (reset)
        data_oe |-> $past(!sp.output_enable_n)) else $error("bus driven without enable");
    lock_after_erase_a: assert property (@(posedge ref_clk) disable iff (reset)
        nvm_req.clear_locks |-> $past(op) == PPP_ERASE_MEM) else $error("locks early");
    eeprom_keep_a: assert property (@(posedge ref_clk) disable iff (reset)
        nvm_req.erase_eeprom |-> !$past(keep_eeprom_fuse)) else $error("eeprom erased");
    entry_still_a: assert property (@(posedge ref_clk) disable iff (reset)
        (entry == PPP_SETTLE && entry_pins != prev_entry_pins) |=> !prog_mode)
        else $error("entry despite pin change");
    ready_idle_a: assert property (@(posedge ref_clk) disable iff (reset)
        (op == PPP_WAIT && nvm_done) |=> ready_busy_flag) else $error("ready not restored");
    page_word_a: assert property (@(posedge ref_clk) disable iff (reset)
        (prog_mode && op == PPP_IDLE && strobe_rise && action == ACT_DATA
        && command == CMD_WR_FLASH && sp.page_latch_byte_sel_one)
        |=> page_buf[word_in_page($past(addr_lo))] == {$past(data_sync), data_lo})
        else $error("page word not buffered");

    erase_c: cover property (@(posedge ref_clk) nvm_req.clear_locks);
    flash_c: cover property (@(posedge ref_clk) nvm_req.flash_page_write);
    entry_c: cover property (@(posedge ref_clk) prog_mode);
    read_c: cover property (@(posedge ref_clk) data_oe && command == CMD_RD_FLASH);
endmodule
`default_nettype wire

// ### bench/ppp_nvm_model.sv
// Stand-in for the storage back end behind the programming port.
// Assumes nvm_req pulses last one cycle; the bench sets the answer latency.
`timescale 1ns/1ps
`default_nettype none
module ppp_nvm_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire ppp_pkg::ppp_nvm_req_t nvm_req,
    input wire logic [7:0] lat,
    output logic nvm_done,
    output logic [7:0] nvm_rd_data
);
    import ppp_pkg::*;
    // ----------------------------------------
    // Read side
    // ----------------------------------------
    // Fixed pattern, distinct from the erased value
    localparam logic [7:0] RD_PATTERN = 8'h3c;
    assign nvm_rd_data = RD_PATTERN;
    // ----------------------------------------
    // Done timing
    // ----------------------------------------
    logic [8:0] left; // Cycles still to go, zero when idle
    logic any_req; // Any operation pulse this cycle
    assign any_req = nvm_req.flash_page_write | nvm_req.eeprom_page_write |
        nvm_req.erase_flash | nvm_req.erase_eeprom | nvm_req.clear_locks |
        nvm_req.fuse_write | nvm_req.lock_write;
    // Countdown; a flash and eeprom erase together earn one done
    always_ff @(posedge ref_clk) begin
        nvm_done <= 1'b0;
        if (reset) begin
            left <= '0;
        end else if (any_req) begin
            left <= {1'b0, lat} + 9'h1;
        end else if (left == 9'h1) begin
            left <= '0;
            nvm_done <= 1'b1;
        end else if (left != '0) begin
            left <= left - 9'h1;
        end
    end
endmodule
`default_nettype wire

// ### bench/test_parallel_program_port.sv
// Self-checking bench for the programming port with a back-end stand-in.
// Assumes a 100 MHz ref_clk; pins change by non-blocking assignment.
`timescale 1ns/1ps
`default_nettype none
module test_parallel_program_port;
    import ppp_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] cmd;
        logic fuse;
        logic [6:0] mask;
        logic [7:0] rd;
        logic busy;
    } ppp_row_t;
    localparam int LIMIT = 30000; // Run needs about 8600 cycles
    localparam ppp_row_t ROWS [11] = '{
        {8'h80, 1'b0, 7'h1c, 8'hff, 1'b1}, {8'h80, 1'b1, 7'h14, 8'hff, 1'b1},
        {8'h40, 1'b0, 7'h02, 8'hff, 1'b1}, {8'h20, 1'b0, 7'h01, 8'hff, 1'b1},
        {8'h10, 1'b0, 7'h40, 8'hff, 1'b1}, {8'h11, 1'b0, 7'h20, 8'hff, 1'b1},
        {8'h08, 1'b0, 7'h00, 8'h3c, 1'b0}, {8'h04, 1'b0, 7'h00, 8'h3c, 1'b0},
        {8'h02, 1'b0, 7'h00, 8'h3c, 1'b0}, {8'h03, 1'b0, 7'h00, 8'h3c, 1'b0},
        {8'h00, 1'b0, 7'h00, 8'hff, 1'b0}};
    logic ref_clk, reset, keep_eeprom_fuse, data_oe, ready_busy_flag, prog_mode, nvm_done;
    logic clr; // Clears the monitor
    ppp_pins_t pins;
    logic [7:0] data_in, data_out, bus_drv, nvm_rd_data, lat;
    ppp_nvm_req_t nvm_req;
    logic [6:0] seen; // Request pulses since clr
    logic [15:0] busy_cnt, cap_addr;
    logic [31:0] cyc;
    int mismatches, n_tests;
    // Bus wire: the device wins only while it enables its drivers
    assign data_in = data_oe ? data_out : bus_drv;
    ppp_port DUT (.ref_clk(ref_clk), .reset(reset), .pins(pins), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .ready_busy_flag(ready_busy_flag),
        .prog_mode(prog_mode), .keep_eeprom_fuse(keep_eeprom_fuse), .nvm_req(nvm_req),
        .nvm_done(nvm_done), .nvm_rd_data(nvm_rd_data));
    ppp_nvm_model nvm (.ref_clk(ref_clk), .reset(reset), .nvm_req(nvm_req), .lat(lat),
        .nvm_done(nvm_done), .nvm_rd_data(nvm_rd_data));
    // ----------------------------------------
    // Clock, monitor and watchdog
    // ----------------------------------------
    always #5 ref_clk = ~ref_clk;
    // Gather request pulses, busy length and the page address
    always @(posedge ref_clk) begin
        if (clr) begin
            seen <= '0;
            busy_cnt <= '0;
        end else begin
            seen <= seen | {nvm_req.flash_page_write, nvm_req.eeprom_page_write,
                nvm_req.erase_flash, nvm_req.erase_eeprom, nvm_req.clear_locks,
                nvm_req.fuse_write, nvm_req.lock_write};
            if (ready_busy_flag === 1'b0) busy_cnt <= busy_cnt + 16'h1;
        end
        if (nvm_req.flash_page_write === 1'b1) cap_addr <= nvm_req.addr;
    end
    // A hang ends the run as a failure
    always @(posedge ref_clk) begin
        cyc <= cyc + 32'h1;
        if (cyc == LIMIT) begin
            mismatches++;
            conclude();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic check_bit(input string what, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic check_val(input string what, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    // one strobe load; each phase held 26 cycles, over 250 ns
    task automatic strobe(input logic [1:0] act, input logic bs1, input logic [7:0] d);
        pins.action_sel_one_byte_sel_two <= act[1];
        pins.action_sel_zero <= act[0];
        pins.page_latch_byte_sel_one <= bs1;
        bus_drv <= d;
        tick(26);
        pins.strobe_clock_pin <= 1'b1;
        tick(26);
        pins.strobe_clock_pin <= 1'b0;
        tick(26);
    endtask
    // Write pulse, then a bounded wait for ready before anything else
    task automatic write_pulse;
        int i;
        clr <= 1'b1;
        tick(1);
        clr <= 1'b0;
        pins.write_n <= 1'b0;
        tick(26);
        pins.write_n <= 1'b1;
        for (i = 0; i < 400 && ready_busy_flag !== 1'b1; i++) tick(1);
        tick(8);
        check_bit("ready_busy_flag", 1'b1, ready_busy_flag);
    endtask
    // Enable pulse; the bench inverts its bus value, which the data_out check does not depend on
    task automatic read_pulse(input logic [7:0] e);
        pins.output_enable_n <= 1'b0;
        bus_drv <= ~bus_drv;
        tick(10);
        @(negedge ref_clk);
        check_bit("data_oe", 1'b1, data_oe);
        check_val("data_out", {8'h00, e}, {8'h00, data_out});
        @(posedge ref_clk);
        pins.output_enable_n <= 1'b1;
        tick(8);
        @(negedge ref_clk);
        check_bit("data_oe", 1'b0, data_oe);
        @(posedge ref_clk);
    endtask
    task automatic conclude;
        $display("counts: %0d checks, %0d mismatches", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        reset = 1'b1;
        pins = '0;
        pins.output_enable_n = 1'b1;
        bus_drv = 8'h00;
        lat = 8'd2;
        keep_eeprom_fuse = 1'b0;
        clr = 1'b0;
        cyc = '0;
        mismatches = 0;
        n_tests = 0;
        tick(8);
        reset <= 1'b0;
        tick(3);
        @(negedge ref_clk);
        check_bit("ready_busy_flag", 1'b1, ready_busy_flag);
        check_bit("prog_mode", 1'b0, prog_mode);
        check_bit("data_oe", 1'b0, data_oe);
        $display("test reset done");
        @(posedge ref_clk);
        // Aborted entry: write_n moves inside the stillness window
        repeat (6) strobe(ACT_ADDR, 1'b0, 8'h00);
        pins.high_voltage <= 1'b1;
        tick(6);
        pins.write_n <= 1'b1;
        tick(30);
        @(negedge ref_clk);
        check_bit("prog_mode", 1'b0, prog_mode);
        @(posedge ref_clk);
        pins.high_voltage <= 1'b0;
        pins.write_n <= 1'b0;
        tick(8);
        // Entry: six toggles, pins 0000, then high voltage with pins still
        repeat (6) strobe(ACT_ADDR, 1'b0, 8'h00);
        pins.high_voltage <= 1'b1;
        tick(30);
        @(negedge ref_clk);
        check_bit("prog_mode", 1'b1, prog_mode);
        @(posedge ref_clk);
        pins.write_n <= 1'b1;
        tick(5000);
        $display("test entry done");
        // Every command code, with fast and slow back-end answers
        // erase row comes first
        for (int k = 0; k < 11; k++) begin
            keep_eeprom_fuse <= ROWS[k].fuse;
            lat <= k[0] ? 8'd40 : 8'd2;
            strobe(ACT_CMD, 1'b0, ROWS[k].cmd);
            write_pulse();
            check_val("req_mask", {9'h0, ROWS[k].mask}, {9'h0, seen});
            check_bit("busy_len", ROWS[k].busy, busy_cnt > {8'h00, lat});
            read_pulse(ROWS[k].rd);
        end
        $display("test command table done");
        // Flash page: two words, then the high address byte
        lat <= 8'd5;
        strobe(ACT_CMD, 1'b0, CMD_WR_FLASH);
        for (int w = 0; w < 2; w++) begin
            strobe(ACT_ADDR, 1'b0, 8'he0 + 8'(w));
            strobe(ACT_DATA, 1'b0, 8'h11 * 8'(w));
            strobe(ACT_DATA, 1'b1, 8'h22);
        end
        strobe(ACT_ADDR, 1'b1, 8'h12);
        write_pulse();
        check_val("page_req", 16'h0040, {9'h0, seen});
        check_val("page_addr", {5'h0, 8'h12, 3'h7}, {5'h0, cap_addr[15:5]});
        // Next page: command and high byte kept, idle strobe ignored
        strobe(ACT_ADDR, 1'b0, 8'h40);
        strobe(ACT_DATA, 1'b0, 8'h33);
        strobe(ACT_DATA, 1'b1, 8'h44);
        strobe(ACT_IDLE, 1'b0, 8'h80);
        write_pulse();
        check_val("page_req", 16'h0040, {9'h0, seen});
        check_val("page_addr", {5'h0, 8'h12, 3'h2}, {5'h0, cap_addr[15:5]});
        $display("test flash page done");
        conclude();
    end
endmodule
`default_nettype wire
